// ---- rtl/smcct_map.vh ----
`ifndef SMCCT_MAP_VH
`define SMCCT_MAP_VH

// ****************************************
// control, format and delay field positions
// ****************************************
`define SMCCT_CTRL_SEL_BIT 0
`define SMCCT_FMT_PHASE_BIT 16
`define SMCCT_FMT_POL_BIT 17
`define SMCCT_FMT_PRESCALE_MSB 15
`define SMCCT_FMT_PRESCALE_LSB 8
`define SMCCT_FMT_MSB 17
`define SMCCT_DLY_C2T_MSB 15
`define SMCCT_DLY_C2T_LSB 8
`define SMCCT_DLY_T2C_MSB 7
`define SMCCT_DLY_T2C_LSB 0
`define SMCCT_DLY_MSB 15

// ****************************************
// word and fifo shape
// ****************************************
`define SMCCT_WORD_BITS 16
`define SMCCT_LAST_EDGE 5'h1f
`define SMCCT_LAST_BIT 5'h0f
`define SMCCT_FIFO_DEPTH 8
`define SMCCT_FIFO_AW 3

// ****************************************
// timing counts in bus-clock cycles, clock and minimum serial clock periods in ns
// ****************************************
`define SMCCT_SETUP_BASE 10'h002
`define SMCCT_SETUP_KEEP_EXTRA 10'h001
`define SMCCT_HOLD_BASE 10'h001
`define SMCCT_PRESCALE_ZERO_PERIOD 9'h002
`define SMCCT_CLK_NS 8
`define SMCCT_MIN_SCK_NS 25
`define SMCCT_MIN_SCK_CYC ((`SMCCT_MIN_SCK_NS + `SMCCT_CLK_NS - 1) / `SMCCT_CLK_NS)

`endif

// ---- rtl/smcct_fifo.v ----
`timescale 1ns/100ps
module smcct_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // fill side
    input wire wr_valid_i,
    output wire wr_ready_o,
    input wire [WIDTH-1:0] wr_data_i,
    // drain side
    output wire rd_valid_o,
    input wire rd_ready_i,
    output wire [WIDTH-1:0] rd_data_o
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    assign wr_ready_o = (count != DEPTH[AW:0]);
    assign rd_valid_o = (count != {(AW+1){1'b0}});
    assign rd_data_o = mem[rd_ptr];
    assign do_wr = wr_valid_i & wr_ready_o;
    assign do_rd = rd_ready_i & rd_valid_o;

    // ****************************************
    // storage
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < DEPTH; g = g + 1) begin : g_slot
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    mem[g] <= {WIDTH{1'b0}};
                end else if (do_wr && {{(32-AW){1'b0}}, wr_ptr} == g) begin
                    mem[g] <= wr_data_i;
                end
            end
        end
    endgenerate

    // ****************************************
    // pointers and fill level
    // ****************************************
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end

endmodule // smcct_fifo

// ---- rtl/smcct_top.v ----
`timescale 1ns/100ps
`include "smcct_map.vh"

module smcct_top (
    // clock and reset
    input wire CLOCK_I,
    input wire RST_N_I,
    // configuration
    input wire [`SMCCT_CTRL_SEL_BIT:0] SPI_GLOBAL_CONTROL_REG_I,
    input wire [`SMCCT_FMT_MSB:0] SPI_FORMAT_REG_I,
    input wire [`SMCCT_DLY_MSB:0] SPI_DELAY_REG_I,
    input wire CS_KEEP_ACTIVE_OPTION_I,
    // transmit stream
    input wire [`SMCCT_WORD_BITS-1:0] TX_DATA_I,
    input wire TX_VALID_I,
    output wire TX_READY_O,
    // receive stream
    output reg [`SMCCT_WORD_BITS-1:0] RX_DATA_O,
    output reg RX_VALID_O,
    // status
    output wire BUSY_O,
    output reg RATE_ERROR_O,
    // serial clock line
    input wire SERIAL_CLOCK_LINE_I,
    output reg SERIAL_CLOCK_LINE_O,
    output wire SERIAL_CLOCK_LINE_OE_O,
    // chip select, active low
    input wire CS_N_I,
    output reg CS_N_O,
    output wire CS_N_OE_O,
    // controller out data line
    input wire CONTROLLER_OUT_DATA_LINE_I,
    output wire CONTROLLER_OUT_DATA_LINE_O,
    output wire CONTROLLER_OUT_DATA_LINE_OE_O,
    // controller in data line
    input wire CONTROLLER_IN_DATA_LINE_I,
    output wire CONTROLLER_IN_DATA_LINE_O,
    output wire CONTROLLER_IN_DATA_LINE_OE_O
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_SETUP = 3'h1;
    localparam [2:0] ST_XFER = 3'h2;
    localparam [2:0] ST_HOLD = 3'h3;
    localparam [2:0] ST_PERI = 3'h4;
    localparam integer MIN_SCK_CYC_FULL = `SMCCT_MIN_SCK_CYC;
    localparam [8:0] MIN_SCK_CYC = MIN_SCK_CYC_FULL[8:0];

    // ****************************************
    // configuration decode
    // ****************************************
    wire ctrl_mode;
    wire phase;
    wire polarity;
    wire [7:0] clock_prescale_value;
    wire [7:0] cs_to_clock_delay_count;
    wire [7:0] clock_to_cs_delay_count;
    wire [8:0] period;
    wire [8:0] half_trail;
    wire [8:0] half_lead;
    wire [9:0] setup_len;

    assign ctrl_mode = SPI_GLOBAL_CONTROL_REG_I[`SMCCT_CTRL_SEL_BIT];
    assign phase = SPI_FORMAT_REG_I[`SMCCT_FMT_PHASE_BIT];
    assign polarity = SPI_FORMAT_REG_I[`SMCCT_FMT_POL_BIT];
    assign clock_prescale_value = SPI_FORMAT_REG_I[`SMCCT_FMT_PRESCALE_MSB:`SMCCT_FMT_PRESCALE_LSB];
    assign cs_to_clock_delay_count = SPI_DELAY_REG_I[`SMCCT_DLY_C2T_MSB:`SMCCT_DLY_C2T_LSB];
    assign clock_to_cs_delay_count = SPI_DELAY_REG_I[`SMCCT_DLY_T2C_MSB:`SMCCT_DLY_T2C_LSB];

    // period split: lead half follows the leading edge, trail half the trailing one
    assign period = (clock_prescale_value == 8'h00) ? `SMCCT_PRESCALE_ZERO_PERIOD
                                                    : {1'b0, clock_prescale_value} + 9'h001;
    assign half_trail = {1'b0, period[8:1]};
    assign half_lead = period - half_trail;

    // chip select to first edge: delay count plus base, plus one when polarity and keep option are both set, plus half a period
    assign setup_len = {2'b00, cs_to_clock_delay_count} + `SMCCT_SETUP_BASE
                     + ((polarity && CS_KEEP_ACTIVE_OPTION_I) ? `SMCCT_SETUP_KEEP_EXTRA : 10'h000)
                     + {1'b0, half_trail};

    // reload value for the timer so that it spans len cycles
    function [9:0] smcct_reload;
        input [9:0] len;
        begin
            smcct_reload = len - 10'h001;
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg [2:0] state;
    reg [9:0] timer;
    reg [4:0] edge_cnt;
    reg [4:0] bit_cnt;
    reg [`SMCCT_WORD_BITS-1:0] tx_sh;
    reg [`SMCCT_WORD_BITS-1:0] rx_sh;
    reg data_out;
    reg sck_prev;

    wire fifo_valid;
    wire [`SMCCT_WORD_BITS-1:0] fifo_data;
    wire fifo_pop;
    wire cs_in_active;
    wire sck_rise;
    wire sck_fall;
    wire same_pp;
    wire lead_edge;
    wire ctl_sample;
    wire ctl_launch;
    wire peri_sample;
    wire peri_launch;
    wire sample_bit;
    wire [`SMCCT_WORD_BITS-1:0] rx_next;
    wire hold_again;

    assign cs_in_active = ~CS_N_I;
    assign sck_rise = SERIAL_CLOCK_LINE_I & ~sck_prev;
    assign sck_fall = ~SERIAL_CLOCK_LINE_I & sck_prev;
    assign same_pp = (polarity == phase);

    // controller: even edges lead, odd edges trail
    assign lead_edge = ~edge_cnt[0];
    assign ctl_sample = phase ? ~lead_edge : lead_edge;
    assign ctl_launch = phase ? (lead_edge && edge_cnt != 5'h00)
                              : (~lead_edge && edge_cnt != `SMCCT_LAST_EDGE);

    // peripheral: edge choice from polarity against phase
    assign peri_sample = same_pp ? sck_fall : sck_rise;
    assign peri_launch = (same_pp ? sck_rise : sck_fall) && bit_cnt != 5'h00;

    assign sample_bit = ctrl_mode ? CONTROLLER_IN_DATA_LINE_I : CONTROLLER_OUT_DATA_LINE_I;
    assign rx_next = {rx_sh[`SMCCT_WORD_BITS-2:0], sample_bit};

    // keep chip select low into the next word when the option asks and data waits
    assign hold_again = CS_KEEP_ACTIVE_OPTION_I && fifo_valid && ctrl_mode;

    assign fifo_pop = (state == ST_IDLE && ctrl_mode && fifo_valid)
                    || (state == ST_IDLE && !ctrl_mode && cs_in_active)
                    || (state == ST_HOLD && timer == 10'h000 && hold_again);

    // ****************************************
    // pin drive
    // ****************************************
    assign SERIAL_CLOCK_LINE_OE_O = ctrl_mode;
    assign CS_N_OE_O = ctrl_mode;
    assign CONTROLLER_OUT_DATA_LINE_O = data_out;
    assign CONTROLLER_OUT_DATA_LINE_OE_O = ctrl_mode;
    assign CONTROLLER_IN_DATA_LINE_O = data_out;
    assign CONTROLLER_IN_DATA_LINE_OE_O = ~ctrl_mode && (state == ST_PERI);
    assign BUSY_O = (state != ST_IDLE);

    // ****************************************
    // transmit fifo
    // ****************************************
    smcct_fifo #(
        .WIDTH(`SMCCT_WORD_BITS),
        .DEPTH(`SMCCT_FIFO_DEPTH),
        .AW(`SMCCT_FIFO_AW)
    ) u_tx_fifo (
        .clk_i(CLOCK_I),
        .rst_n_i(RST_N_I),
        .wr_valid_i(TX_VALID_I),
        .wr_ready_o(TX_READY_O),
        .wr_data_i(TX_DATA_I),
        .rd_valid_o(fifo_valid),
        .rd_ready_i(fifo_pop),
        .rd_data_o(fifo_data)
    );

    // ****************************************
    // sequencer
    // ****************************************
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state <= ST_IDLE;
            timer <= 10'h000;
            edge_cnt <= 5'h00;
            bit_cnt <= 5'h00;
            tx_sh <= 16'h0000;
            rx_sh <= 16'h0000;
            data_out <= 1'b0;
            sck_prev <= 1'b0;
            SERIAL_CLOCK_LINE_O <= 1'b0;
            CS_N_O <= 1'b1;
            RX_DATA_O <= 16'h0000;
            RX_VALID_O <= 1'b0;
            RATE_ERROR_O <= 1'b0;
        end else begin
            RX_VALID_O <= 1'b0;
            sck_prev <= SERIAL_CLOCK_LINE_I;
            RATE_ERROR_O <= (period < MIN_SCK_CYC);
            case (state)
                ST_IDLE: begin
                    CS_N_O <= 1'b1;
                    SERIAL_CLOCK_LINE_O <= polarity;
                    if (ctrl_mode && fifo_valid) begin
                        CS_N_O <= 1'b0;
                        tx_sh <= fifo_data;
                        data_out <= fifo_data[`SMCCT_WORD_BITS-1];
                        edge_cnt <= 5'h00;
                        timer <= smcct_reload(setup_len);
                        state <= ST_SETUP;
                    end else if (!ctrl_mode && cs_in_active) begin
                        tx_sh <= fifo_valid ? fifo_data : 16'h0000;
                        data_out <= fifo_valid & fifo_data[`SMCCT_WORD_BITS-1];
                        bit_cnt <= 5'h00;
                        state <= ST_PERI;
                    end
                end
                ST_SETUP, ST_XFER: begin
                    if (!ctrl_mode) begin
                        CS_N_O <= 1'b1;
                        state <= ST_IDLE;
                    end else if (timer != 10'h000) begin
                        timer <= timer - 10'h001;
                    end else begin
                        SERIAL_CLOCK_LINE_O <= ~SERIAL_CLOCK_LINE_O;
                        if (ctl_sample) begin
                            rx_sh <= rx_next;
                        end
                        if (ctl_launch) begin
                            data_out <= tx_sh[`SMCCT_WORD_BITS-2];
                            tx_sh <= {tx_sh[`SMCCT_WORD_BITS-2:0], 1'b0};
                        end
                        edge_cnt <= edge_cnt + 5'h01;
                        if (edge_cnt == `SMCCT_LAST_EDGE) begin
                            RX_DATA_O <= ctl_sample ? rx_next : rx_sh;
                            RX_VALID_O <= 1'b1;
                            timer <= smcct_reload(`SMCCT_HOLD_BASE + {2'b00, clock_to_cs_delay_count});
                            state <= ST_HOLD;
                        end else begin
                            timer <= smcct_reload(lead_edge ? {1'b0, half_lead} : {1'b0, half_trail});
                            state <= ST_XFER;
                        end
                    end
                end
                ST_HOLD: begin
                    if (!ctrl_mode) begin
                        CS_N_O <= 1'b1;
                        state <= ST_IDLE;
                    end else if (timer != 10'h000) begin
                        timer <= timer - 10'h001;
                    end else if (hold_again) begin
                        tx_sh <= fifo_data;
                        data_out <= fifo_data[`SMCCT_WORD_BITS-1];
                        edge_cnt <= 5'h00;
                        timer <= smcct_reload(setup_len);
                        state <= ST_SETUP;
                    end else begin
                        CS_N_O <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                ST_PERI: begin
                    if (ctrl_mode || !cs_in_active) begin
                        state <= ST_IDLE;
                    end else begin
                        if (peri_sample) begin
                            rx_sh <= rx_next;
                            if (bit_cnt == `SMCCT_LAST_BIT) begin
                                RX_DATA_O <= rx_next;
                                RX_VALID_O <= 1'b1;
                                bit_cnt <= 5'h00;
                            end else begin
                                bit_cnt <= bit_cnt + 5'h01;
                            end
                        end
                        if (peri_launch) begin
                            data_out <= tx_sh[`SMCCT_WORD_BITS-2];
                            tx_sh <= {tx_sh[`SMCCT_WORD_BITS-2:0], 1'b0};
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // smcct_top

// ---- testbench/smcct_top_props.sv ----
`timescale 1ns/100ps
`include "smcct_map.vh"
module smcct_top_props (
    // clock and reset
    input wire CLOCK_I,
    input wire RST_N_I,
    // configuration
    input wire [`SMCCT_CTRL_SEL_BIT:0] SPI_GLOBAL_CONTROL_REG_I,
    input wire [`SMCCT_FMT_MSB:0] SPI_FORMAT_REG_I,
    input wire [`SMCCT_DLY_MSB:0] SPI_DELAY_REG_I,
    input wire CS_KEEP_ACTIVE_OPTION_I,
    // status
    input wire TX_READY_O,
    input wire RX_VALID_O,
    input wire BUSY_O,
    input wire RATE_ERROR_O,
    // pins
    input wire SERIAL_CLOCK_LINE_O,
    input wire SERIAL_CLOCK_LINE_OE_O,
    input wire CS_N_O,
    input wire CS_N_OE_O,
    input wire CONTROLLER_OUT_DATA_LINE_OE_O,
    input wire CONTROLLER_IN_DATA_LINE_OE_O
);
    reg sclk_q, cs_q, pend;
    reg [9:0] since_tog, since_cs;
    wire ctrl = SPI_GLOBAL_CONTROL_REG_I[0];
    wire pol = SPI_FORMAT_REG_I[17];
    wire [7:0] presc = SPI_FORMAT_REG_I[15:8];
    wire [8:0] per = (presc == 8'h00) ? 9'h002 : {1'b0, presc} + 9'h001;
    wire [9:0] setup = {2'h0, SPI_DELAY_REG_I[15:8]} + 10'h002 + {9'h000, pol & CS_KEEP_ACTIVE_OPTION_I} + {2'h0, per[8:1]};
    wire [9:0] hold = {2'h0, SPI_DELAY_REG_I[7:0]} + 10'h001;
    wire tog = SERIAL_CLOCK_LINE_O != sclk_q;
    // ****************************************
    // cycle counters since clock toggle and chip-select fall
    // ****************************************
    always @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
            pend <= 1'b0;
            since_tog <= 10'h000;
            since_cs <= 10'h000;
        end else begin
            sclk_q <= SERIAL_CLOCK_LINE_O;
            cs_q <= CS_N_O;
            pend <= (cs_q & ~CS_N_O) | (pend & ~tog);
            since_tog <= tog ? 10'h001 : since_tog + {9'h000, ~&since_tog};
            since_cs <= (cs_q & ~CS_N_O) ? 10'h001 : since_cs + {9'h000, ~&since_cs};
        end
    end
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    a_ctrl_drives_pins: assert property (SERIAL_CLOCK_LINE_OE_O == ctrl && CS_N_OE_O == ctrl
        && CONTROLLER_OUT_DATA_LINE_OE_O == ctrl) else $error("controller pin enables do not follow mode");
    a_periph_resp_only: assert property (CONTROLLER_IN_DATA_LINE_OE_O |-> !ctrl)
        else $error("response line driven in controller mode");
    a_idle_clk_level: assert property ($past(RST_N_I) && ctrl && $past(ctrl) && !BUSY_O && $past(!BUSY_O)
        && $stable(pol) |-> SERIAL_CLOCK_LINE_O == pol) else $error("idle serial clock not at polarity");
    a_cs_setup_count: assert property (ctrl && tog && pend |-> since_cs == setup)
        else $error("chip select to first edge count wrong");
    a_clk_half_period: assert property (ctrl && tog && !pend && !CS_N_O && !CS_KEEP_ACTIVE_OPTION_I
        |-> since_tog == {2'h0, per[8:1]} || since_tog == {1'b0, per - {1'b0, per[8:1]}})
        else $error("serial clock half period wrong");
    a_cs_hold_count: assert property (ctrl && $past(ctrl) && $rose(CS_N_O) |-> since_tog == hold)
        else $error("last edge to chip select release count wrong");
    a_cs_idle_high: assert property (ctrl && $past(ctrl) && !BUSY_O && $past(!BUSY_O) |-> CS_N_O)
        else $error("chip select active while idle");
    a_rate_flag: assert property ($past(RST_N_I) && $stable(presc) |-> RATE_ERROR_O == (per < 9'h004))
        else $error("rate flag does not match prescale");
    a_rx_one_pulse: assert property (RX_VALID_O |=> !RX_VALID_O)
        else $error("receive valid longer than one cycle");
    c_ctrl_word: cover property (ctrl && $rose(CS_N_O));
    c_periph_word: cover property (!ctrl && RX_VALID_O);
    c_fifo_full: cover property (!TX_READY_O);
endmodule // smcct_top_props

bind smcct_top smcct_top_props i_smcct_top_props (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I),
    .SPI_GLOBAL_CONTROL_REG_I(SPI_GLOBAL_CONTROL_REG_I), .SPI_FORMAT_REG_I(SPI_FORMAT_REG_I),
    .SPI_DELAY_REG_I(SPI_DELAY_REG_I), .CS_KEEP_ACTIVE_OPTION_I(CS_KEEP_ACTIVE_OPTION_I), .TX_READY_O(TX_READY_O),
    .RX_VALID_O(RX_VALID_O), .BUSY_O(BUSY_O), .RATE_ERROR_O(RATE_ERROR_O), .SERIAL_CLOCK_LINE_O(SERIAL_CLOCK_LINE_O),
    .SERIAL_CLOCK_LINE_OE_O(SERIAL_CLOCK_LINE_OE_O), .CS_N_O(CS_N_O), .CS_N_OE_O(CS_N_OE_O),
    .CONTROLLER_OUT_DATA_LINE_OE_O(CONTROLLER_OUT_DATA_LINE_OE_O),
    .CONTROLLER_IN_DATA_LINE_OE_O(CONTROLLER_IN_DATA_LINE_OE_O));

// ---- testbench/smcct_periph_model.sv ----
`timescale 1ns/100ps
module smcct_periph_model (
    // bus clock
    input wire clk_i,
    // serial pins and clock phase
    input wire cs_n_i,
    input wire sclk_i,
    input wire pha_i,
    input wire mosi_i,
    output reg miso_o,
    // words
    input wire [15:0] reply_i,
    output reg [15:0] got_o
);
    reg sclk_q = 1'b0;
    reg cs_q = 1'b1;
    reg [4:0] n = 5'h00;
    reg [15:0] sh = 16'h0000;
    initial miso_o = 1'b0;
    initial got_o = 16'h0000;
    // ****************************************
    // edge-counting peripheral
    // ****************************************
    always @(posedge clk_i) begin
        sclk_q <= sclk_i;
        cs_q <= cs_n_i;
        if (cs_n_i) begin
            miso_o <= ~miso_o;
            n <= 5'h00;
        end else if (cs_q) begin
            miso_o <= reply_i[15];
            sh <= pha_i ? reply_i : {reply_i[14:0], 1'b0};
        end else if (sclk_i != sclk_q) begin
            n <= n + 5'h01;
            if (n[0] == pha_i)
                got_o <= {got_o[14:0], mosi_i};
            else begin
                miso_o <= sh[15];
                sh <= {sh[14:0], 1'b0};
            end
        end
    end
endmodule // smcct_periph_model

// ---- testbench/smcct_top_tb.sv ----
`timescale 1ns/100ps
module smcct_top_tb;
    // ****************************************
    // clock, pins and partner
    // ****************************************
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg ctrl = 1'b1;
    reg [17:0] fmt = 18'h00300;
    reg [15:0] dly = 16'h0000;
    reg keep = 1'b0;
    reg [15:0] txd = 16'h0000;
    reg txv = 1'b0;
    reg h_cs_n = 1'b1;
    reg h_sclk = 1'b0;
    reg h_mosi = 1'b0;
    reg rel_tog = 1'b0;
    reg [15:0] reply = 16'h0000;
    wire [15:0] rxd, got;
    wire txr, busy, rerr, rxv, sck_o, sck_oe, cs_o, cs_oe, mo_o, mo_oe, mi_o, mi_oe, m_miso;
    wire sck = sck_oe ? sck_o : h_sclk;
    wire cs_n = cs_oe ? cs_o : h_cs_n;
    wire mosi = mo_oe ? mo_o : (h_cs_n ? rel_tog : h_mosi);
    wire miso = mi_oe ? mi_o : m_miso;
    integer mismatches = 0;
    integer checked = 0;
    always #4 clk = ~clk;
    // released host data line keeps changing
    always @(negedge clk) rel_tog <= ~rel_tog;
    smcct_top i_smcct_top (.CLOCK_I(clk), .RST_N_I(rst_n), .SPI_GLOBAL_CONTROL_REG_I(ctrl), .SPI_FORMAT_REG_I(fmt),
        .SPI_DELAY_REG_I(dly), .CS_KEEP_ACTIVE_OPTION_I(keep), .TX_DATA_I(txd), .TX_VALID_I(txv), .TX_READY_O(txr),
        .RX_DATA_O(rxd), .RX_VALID_O(rxv), .BUSY_O(busy), .RATE_ERROR_O(rerr), .SERIAL_CLOCK_LINE_I(sck),
        .SERIAL_CLOCK_LINE_O(sck_o), .SERIAL_CLOCK_LINE_OE_O(sck_oe), .CS_N_I(cs_n), .CS_N_O(cs_o), .CS_N_OE_O(cs_oe),
        .CONTROLLER_OUT_DATA_LINE_I(mosi), .CONTROLLER_OUT_DATA_LINE_O(mo_o), .CONTROLLER_OUT_DATA_LINE_OE_O(mo_oe),
        .CONTROLLER_IN_DATA_LINE_I(miso), .CONTROLLER_IN_DATA_LINE_O(mi_o), .CONTROLLER_IN_DATA_LINE_OE_O(mi_oe));
    smcct_periph_model i_smcct_periph_model (.clk_i(clk), .cs_n_i(cs_n), .sclk_i(sck), .pha_i(fmt[16]),
        .mosi_i(mosi), .reply_i(reply), .miso_o(m_miso), .got_o(got));
    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input [31:0] g, input [31:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("checked %0d mismatches %0d", checked, mismatches);
            if (mismatches == 0 && checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task ctrl_word(input [1:0] m, input [7:0] pre, input [7:0] c2t, input [7:0] t2c, input kp, input dat);
        integer n, t0, t1, t3, tl, tg;
        reg [8:0] p;
        reg sq, cq;
        begin
            @(negedge clk);
            ctrl = 1'b1;
            fmt = {m, pre, 8'h00};
            dly = {c2t, t2c};
            keep = kp;
            reply = 16'h5a3c ^ {8'h00, pre};
            p = (pre == 8'h00) ? 9'h002 : {1'b0, pre} + 9'h001;
            repeat (2) @(negedge clk);
            chk(rerr, p < 9'h004);
            chk(sck_o, m[1]);
            txd = 16'hc3a5 ^ {pre, pre};
            txv = 1'b1;
            @(negedge clk);
            txv = 1'b0;
            n = 0;
            tg = 0;
            t0 = 0;
            t1 = 0;
            t3 = 0;
            tl = 0;
            sq = sck_o;
            cq = cs_o;
            while (n < 9000 && !(t0 != 0 && cs_o)) begin
                @(negedge clk);
                n = n + 1;
                if (cq && !cs_o)
                    t0 = n;
                if (sck_o !== sq) begin
                    tg = tg + 1;
                    if (tg == 1)
                        t1 = n;
                    if (tg == 3)
                        t3 = n;
                    tl = n;
                end
                sq = sck_o;
                cq = cs_o;
            end
            chk(t1 - t0, c2t + 2 + (m[1] & kp) + p / 2);
            chk(t3 - t1, p);
            chk(tg, 32);
            chk(n - tl, t2c + 1);
            if (dat) begin
                chk(rxd, 16'h5a3c ^ {8'h00, pre});
                chk(got, 16'hc3a5 ^ {pre, pre});
            end
        end
    endtask
    task keep_pair;
        integer n, tg, nv;
        reg sq, lo;
        begin
            @(negedge clk);
            ctrl = 1'b1;
            fmt = {2'h0, 8'h03, 8'h00};
            dly = 16'h0102;
            keep = 1'b1;
            txd = 16'h1234;
            txv = 1'b1;
            @(negedge clk);
            txd = 16'hedcb;
            @(negedge clk);
            txv = 1'b0;
            n = 0;
            tg = 0;
            nv = 0;
            lo = 1'b0;
            sq = sck_o;
            while (n < 2000 && !(lo && cs_o)) begin
                @(negedge clk);
                n = n + 1;
                if (!cs_o)
                    lo = 1'b1;
                if (sck_o !== sq)
                    tg = tg + 1;
                if (rxv)
                    nv = nv + 1;
                sq = sck_o;
            end
            keep = 1'b0;
            chk(tg, 64);
            chk(nv, 2);
            chk(got, 16'hedcb);
        end
    endtask
    task per_word(input [1:0] m, input [15:0] w, input [15:0] e);
        integer k, nb;
        reg [15:0] r;
        begin
            @(negedge clk);
            ctrl = 1'b0;
            fmt = {m, 8'h03, 8'h00};
            h_sclk = m[1];
            @(negedge clk);
            h_cs_n = 1'b0;
            @(negedge clk);
            h_mosi = w[15];
            nb = 0;
            r = 16'h0000;
            repeat (16) @(negedge clk);
            for (k = 0; k < 32; k = k + 1) begin
                if (k[0] != m[0]) begin
                    r = {r[14:0], miso};
                    nb = nb + 1;
                end else if (nb > 0 && nb < 16)
                    h_mosi = w[15 - nb];
                h_sclk = ~h_sclk;
                repeat (4) @(negedge clk);
            end
            h_cs_n = 1'b1;
            repeat (4) @(negedge clk);
            chk(rxd, w);
            chk(r, e);
        end
    endtask
    task fifo_fill;
        integer k, i;
        reg acc;
        begin
            @(negedge clk);
            ctrl = 1'b0;
            k = 0;
            for (i = 0; i < 10; i = i + 1) begin
                txd = 16'h9100 + k[15:0];
                txv = 1'b1;
                acc = txr;
                @(negedge clk);
                if (acc)
                    k = k + 1;
            end
            txv = 1'b0;
            chk(k, 8);
            chk(txr, 1'b0);
            for (i = 0; i < 8; i = i + 1)
                per_word(i[1:0], 16'h3c00 + i[15:0], 16'h9100 + i[15:0]);
            per_word(2'h1, 16'h0f0f, 16'h0000);
            chk(txr, 1'b1);
        end
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        ctrl_word(2'h0, 8'h03, 8'h01, 8'h03, 1'b0, 1'b1);
        ctrl_word(2'h1, 8'h04, 8'h02, 8'h00, 1'b0, 1'b1);
        ctrl_word(2'h2, 8'h03, 8'h00, 8'h02, 1'b1, 1'b1);
        ctrl_word(2'h3, 8'hff, 8'h05, 8'h01, 1'b1, 1'b1);
        ctrl_word(2'h0, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
        keep_pair;
        fifo_fill;
        give_verdict;
    end
    initial begin
        #(40000 * 8);
        mismatches = mismatches + 1;
        give_verdict;
    end
endmodule // smcct_top_tb
